/* File: design/vpic_controller.sv */
// Vectored priority interrupt controller with AXI4-Lite register access.
`timescale 1ns/1ps
// Notes on behaviour
// - Sources 0-8 and 16-18 exist, others read zero.
// - Vector read returns highest-priority source's vector.
// - Normal request from eight-level priority encoder.
// - Highest level wins, ties go to lowest number.
// - Current level taken at vector read.
// - Late higher request updates vector before read.
// - Higher request after read reasserts, nests level.
// - End-of-interrupt pops the stacked level.
// - Vector read drops request, clears edge source.
// - Enable commands set mask bits, disable commands clear them.
// - Disabled source takes no part in resolution.
// - Set and clear commands drive edge pending bits.
// - Only fast input drives fast request directly.
// - Fast source selects edge or level polarity.
// - Fast vector read returns source zero vector.
// - Nothing pending returns the spurious vector.
// - After spurious, no requests until EOI written.
// - Protect mode: read harmless, write commits context.
// - Vector write does nothing in normal mode.
// - Internal sources level/edge, external full polarity.
// - Mode entry priority field, ignored for source zero.
module vpic_controller #(
  parameter int unsigned NUM_SOURCES = vpic_pkg::NUM_SOURCES,
  parameter int unsigned STACK_DEPTH = vpic_pkg::STACK_DEPTH
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] sources_i,
  output logic             core_irq_request_o,
  output logic             core_fast_irq_request_o,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);
  initial begin
    if (NUM_SOURCES != 32) $error("vpic_controller serves exactly 32 sources");
    if (STACK_DEPTH < 8) $error("vpic_controller needs a stack of at least 8");
  end

  localparam logic [31:0] PRESENT  = vpic_pkg::SOURCES_PRESENT;
  localparam logic [31:0] INTERNAL = vpic_pkg::INTERNAL_SOURCES;
  localparam int SPW = $clog2(STACK_DEPTH + 1);

  // Two-stage synchroniser; the first stage feeds only the second.
  logic [31:0] sync_a;
  logic [31:0] sync_b;
  logic [31:0] sync_prev;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a    <= 32'h0000_0000;
      sync_b    <= 32'h0000_0000;
      sync_prev <= 32'h0000_0000;
    end else begin
      sync_a    <= sources_i & PRESENT;
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  logic [31:0]        mode_prio [32];
  logic [1:0]         mode_type [32];
  logic [31:0]        vec_tab [32];
  logic [31:0]        mask;
  logic [31:0]        edge_pend;
  logic [31:0]        spurious_vec;
  logic               protect;
  logic               spurious_lock;
  logic               in_service;
  logic [2:0]         cur_level;
  logic [4:0]         cur_source;
  logic [2:0]         lvl_stack [STACK_DEPTH];
  logic [4:0]         src_stack [STACK_DEPTH];
  logic [SPW-1:0]     sp;
  logic               armed;
  logic [4:0]         armed_src;
  logic               armed_spur;

  // Per-source active level: internal ones allow high level or rising edge only.
  logic [31:0] is_edge;
  logic [31:0] active;
  logic [31:0] edge_seen;
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_src
      logic [1:0] st;
      assign st = INTERNAL[g] ? {1'b1, mode_type[g][0]} : mode_type[g];
      assign is_edge[g] = st[0] & PRESENT[g];
      assign edge_seen[g] = st[1] ? (sync_b[g] & ~sync_prev[g]) : (~sync_b[g] & sync_prev[g]);
      assign active[g] = PRESENT[g] & (st[0] ? edge_pend[g] : (st[1] ? sync_b[g] : ~sync_b[g]));
    end
  endgenerate

  // Priority encoder over enabled normal sources.
  logic [31:0] eligible;
  logic        best_valid;
  logic [4:0]  best_src;
  logic [2:0]  best_prio;
  assign eligible = active & mask & PRESENT & 32'hFFFF_FFFE;
  always_comb begin
    best_valid = 1'b0;
    best_src   = 5'd0;
    best_prio  = 3'd0;
    for (int i = 31; i >= 1; i--) begin
      if (eligible[i] && (!best_valid || mode_prio[i][2:0] >= best_prio)) begin
        best_valid = 1'b1;
        best_src   = 5'(i);
        best_prio  = mode_prio[i][2:0];
      end
    end
  end

  logic beats_current;
  assign beats_current = best_valid && (!in_service || best_prio > cur_level);

  // AXI4-Lite write path: address and data latched independently.
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic [11:0] wa;
  logic [31:0] wd;
  assign wr_go = (aw_held | s_axi_awvalid_i) & (w_held | s_axi_wvalid_i) & ~s_axi_bvalid_o;
  assign wa = aw_held ? aw_addr : s_axi_awaddr_i;
  assign wd = w_held ? w_data : s_axi_wdata_i;
  logic wr_full;
  assign wr_full = (w_held ? w_strb : s_axi_wstrb_i) == 4'hF;

  logic wr_mode;
  logic wr_vec;
  assign wr_mode = wr_go && wr_full && wa < vpic_pkg::OFS_VECTOR_BASE;
  assign wr_vec  = wr_go && wr_full && wa >= vpic_pkg::OFS_VECTOR_BASE && wa < vpic_pkg::OFS_IRQ_VECTOR;
  logic [4:0] wr_idx;
  assign wr_idx = wa[6:2];
  logic wr_cmd;
  assign wr_cmd = wr_go && wr_full;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= vpic_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (wa > vpic_pkg::OFS_PROTECT || wa[1:0] != 2'b00) ? vpic_pkg::RESP_SLVERR
                                                                           : vpic_pkg::RESP_OKAY;
      end else begin
        if (s_axi_awvalid_i && s_axi_awready_o) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata_i;
          w_strb <= s_axi_wstrb_i;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end
    end
  end
  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;

  // Configuration storage; absent sources stay zero.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        mode_prio[i] <= vpic_pkg::MODE_RESET;
        mode_type[i] <= 2'b00;
        vec_tab[i]   <= vpic_pkg::VECTOR_RESET;
      end
      spurious_vec <= 32'h0000_0000;
      protect      <= 1'b0;
    end else begin
      if (wr_mode && PRESENT[wr_idx]) begin
        mode_prio[wr_idx] <= (wr_idx == 5'd0) ? 32'h0000_0000 : {29'd0, wd[2:0]};
        mode_type[wr_idx] <= wd[6:5];
      end
      if (wr_vec && PRESENT[wr_idx]) begin
        vec_tab[wr_idx] <= wd;
      end
      if (wr_cmd && wa == vpic_pkg::OFS_SPURIOUS) begin
        spurious_vec <= wd;
      end
      if (wr_cmd && wa == vpic_pkg::OFS_PROTECT) begin
        protect <= wd[0];
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask <= 32'h0000_0000;
    end else if (wr_cmd && wa == vpic_pkg::OFS_ENABLE) begin
      mask <= mask | (wd & PRESENT);
    end else if (wr_cmd && wa == vpic_pkg::OFS_DISABLE) begin
      mask <= mask & ~wd;
    end
  end

  // Read decode and vector-read side effects.
  logic        rd_go;
  logic [11:0] ra;
  assign rd_go = s_axi_arvalid_i & ~s_axi_rvalid_o;
  assign ra = s_axi_araddr_i;
  logic ivr_read;
  logic fvr_read;
  logic ivr_write;
  assign ivr_read  = rd_go && ra == vpic_pkg::OFS_IRQ_VECTOR;
  assign fvr_read  = rd_go && ra == vpic_pkg::OFS_FAST_VECTOR;
  assign ivr_write = wr_cmd && wa == vpic_pkg::OFS_IRQ_VECTOR;
  logic commit;
  logic commit_spur;
  logic [4:0] commit_src;
  assign commit      = protect ? (ivr_write && armed) : ivr_read;
  assign commit_spur = protect ? armed_spur : ~beats_current;
  assign commit_src  = protect ? armed_src : best_src;
  logic eoi;
  assign eoi = wr_cmd && wa == vpic_pkg::OFS_EOI;

  logic fast_active;
  assign fast_active = active[0] & mask[0];

  // Edge pending bits: a new edge wins over any clear in the same cycle.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      edge_pend <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (is_edge[i] && (edge_seen[i] || (wr_cmd && wa == vpic_pkg::OFS_SET && wd[i]))) begin
          edge_pend[i] <= 1'b1;
        end else if (wr_cmd && wa == vpic_pkg::OFS_CLEAR && wd[i]) begin
          edge_pend[i] <= 1'b0;
        end else if (commit && !commit_spur && commit_src == 5'(i)) begin
          edge_pend[i] <= 1'b0;
        end else if (i == 0 && fvr_read && !protect) begin
          edge_pend[i] <= 1'b0;
        end
      end
    end
  end

  // Level nesting stack and current context.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sp            <= '0;
      cur_level     <= 3'd0;
      cur_source    <= 5'd0;
      in_service    <= 1'b0;
      spurious_lock <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        lvl_stack[i] <= 3'd0;
        src_stack[i] <= 5'd0;
      end
    end else if (commit) begin
      if (commit_spur) begin
        spurious_lock <= 1'b1;
      end else begin
        if (in_service && sp < SPW'(STACK_DEPTH)) begin
          lvl_stack[sp[$clog2(STACK_DEPTH)-1:0]] <= cur_level;
          src_stack[sp[$clog2(STACK_DEPTH)-1:0]] <= cur_source;
          sp <= sp + SPW'(1);
        end
        cur_level  <= mode_prio[commit_src][2:0];
        cur_source <= commit_src;
        in_service <= 1'b1;
      end
    end else if (eoi) begin
      if (spurious_lock) begin
        spurious_lock <= 1'b0;
      end else if (sp != '0) begin
        cur_level  <= lvl_stack[sp[$clog2(STACK_DEPTH)-1:0] - 1'b1];
        cur_source <= src_stack[sp[$clog2(STACK_DEPTH)-1:0] - 1'b1];
        sp <= sp - SPW'(1);
      end else begin
        in_service <= 1'b0;
        cur_level  <= 3'd0;
        cur_source <= 5'd0;
      end
    end
  end

  // Protect mode remembers what the harmless read showed.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      armed      <= 1'b0;
      armed_src  <= 5'd0;
      armed_spur <= 1'b0;
    end else if (protect && ivr_read) begin
      armed      <= 1'b1;
      armed_src  <= best_src;
      armed_spur <= ~beats_current;
    end else if (ivr_write || !protect) begin
      armed <= 1'b0;
    end
  end

  // Request lines; the normal request is held off after a vector read until something higher arrives or an EOI is written.
  logic irq_acked;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_acked <= 1'b0;
    end else if (ivr_read) begin
      irq_acked <= 1'b1;
    end else if (eoi || (commit && !protect)) begin
      irq_acked <= 1'b0;
    end else if (commit) begin
      irq_acked <= 1'b0;
    end
  end

  logic [2:0] ack_level;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_level <= 3'd0;
    end else if (ivr_read) begin
      ack_level <= beats_current ? best_prio : cur_level;
    end
  end
  logic irq_want;
  assign irq_want = beats_current && !spurious_lock && (!irq_acked || best_prio > ack_level);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      core_irq_request_o      <= 1'b0;
      core_fast_irq_request_o <= 1'b0;
    end else begin
      core_irq_request_o      <= irq_want && !ivr_read && !commit;
      core_fast_irq_request_o <= fast_active && !spurious_lock && !fvr_read;
    end
  end

  // Read data mux.
  logic [31:0] rd_val;
  logic        rd_err;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (ra < vpic_pkg::OFS_VECTOR_BASE) begin
      rd_val = {25'd0, mode_type[ra[6:2]], 2'b00, mode_prio[ra[6:2]][2:0]};
    end else if (ra < vpic_pkg::OFS_IRQ_VECTOR) begin
      rd_val = vec_tab[ra[6:2]];
    end else begin
      case (ra)
        vpic_pkg::OFS_IRQ_VECTOR:  rd_val = beats_current ? vec_tab[best_src] : spurious_vec;
        vpic_pkg::OFS_FAST_VECTOR: rd_val = fast_active ? vec_tab[vpic_pkg::FAST_SOURCE] : spurious_vec;
        vpic_pkg::OFS_STATUS:      rd_val = {27'd0, cur_source};
        vpic_pkg::OFS_PENDING:     rd_val = active;
        vpic_pkg::OFS_MASK:        rd_val = mask;
        vpic_pkg::OFS_CORE_STATUS: rd_val = {30'd0, core_irq_request_o, core_fast_irq_request_o};
        vpic_pkg::OFS_SPURIOUS:    rd_val = spurious_vec;
        vpic_pkg::OFS_PROTECT:     rd_val = {31'd0, protect};
        vpic_pkg::OFS_ENABLE, vpic_pkg::OFS_DISABLE, vpic_pkg::OFS_CLEAR,
        vpic_pkg::OFS_SET, vpic_pkg::OFS_EOI: rd_val = 32'h0000_0000;
        default:                   rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= vpic_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_val;
      s_axi_rresp_o  <= (rd_err || ra[1:0] != 2'b00) ? vpic_pkg::RESP_SLVERR : vpic_pkg::RESP_OKAY;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
  assign s_axi_arready_o = ~s_axi_rvalid_o;
endmodule // vpic_controller

/* File: design/vpic_pkg.sv */
// Package of constants and types for the vectored priority interrupt controller.
package vpic_pkg;
  localparam int unsigned NUM_SOURCES = 32;
  localparam int unsigned NUM_LEVELS  = 8;
  localparam int unsigned STACK_DEPTH = 8;
  localparam logic [31:0] SOURCES_PRESENT = 32'h0007_01FF;
  localparam logic [31:0] INTERNAL_SOURCES = 32'h0000_01FE;
  localparam int unsigned FAST_SOURCE = 0;
  localparam int unsigned EXT_BASE = 16;
  localparam logic [11:0] OFS_MODE_BASE   = 12'h000;
  localparam logic [11:0] OFS_VECTOR_BASE = 12'h080;
  localparam logic [11:0] OFS_IRQ_VECTOR  = 12'h100;
  localparam logic [11:0] OFS_FAST_VECTOR = 12'h104;
  localparam logic [11:0] OFS_STATUS      = 12'h108;
  localparam logic [11:0] OFS_PENDING     = 12'h10C;
  localparam logic [11:0] OFS_MASK        = 12'h110;
  localparam logic [11:0] OFS_CORE_STATUS = 12'h114;
  localparam logic [11:0] OFS_ENABLE      = 12'h120;
  localparam logic [11:0] OFS_DISABLE     = 12'h124;
  localparam logic [11:0] OFS_CLEAR       = 12'h128;
  localparam logic [11:0] OFS_SET         = 12'h12C;
  localparam logic [11:0] OFS_EOI         = 12'h130;
  localparam logic [11:0] OFS_SPURIOUS    = 12'h134;
  localparam logic [11:0] OFS_PROTECT     = 12'h138;
  localparam int unsigned PRIO_LSB = 0;
  localparam int unsigned TYPE_LSB = 5;
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam logic [31:0] VECTOR_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    VPIC_LOW_LEVEL  = 2'b00,
    VPIC_FALL_EDGE  = 2'b01,
    VPIC_HIGH_LEVEL = 2'b10,
    VPIC_RISE_EDGE  = 2'b11
  } vpic_srctype_t;
  typedef struct packed {
    logic [2:0]  prio;
    logic [1:0]  srctype;
  } vpic_mode_t;
endpackage

/* File: dv/tb_top.sv */
// Testbench driving the controller through its register bus and source lines.
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, irq, fiq, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] lvl, src, wdata, rdata, d;
  logic [11:0] awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          error_cnt, n_checks;
  vpic_controller vpic_controller_inst (
    .clock_i(clk), .rst_i(rst), .sources_i(src), .core_irq_request_o(irq), .core_fast_irq_request_o(fiq),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready));
  vpic_src_model vpic_src_model_inst (.clock_i(clk), .rst_i(rst), .level_i(lvl), .sources_o(src));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  function automatic logic [11:0] md(input int k);
    return vpic_pkg::OFS_MODE_BASE + 12'(4 * k);
  endfunction
  function automatic logic [31:0] vec(input int k);
    return 32'h0000_0A00 + 32'(k);
  endfunction
  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bit ad;
    bit wd;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    ad = 0;
    wd = 0;
    while (!(ad && wd)) begin
      @(posedge clk);
      ad |= awready;
      wd |= wready;
      if (ad) awvalid <= 1'h0;
      if (wd) wvalid <= 1'h0;
    end
    do @(posedge clk); while (bvalid !== 1'h1);
    chk("write response", {30'h0, bresp}, {30'h0, vpic_pkg::RESP_OKAY});
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("register %h", a), d, e);
  endtask
  // Waits out the two-flop sync and the registered request pins.
  task automatic pins(input logic [1:0] e);
    repeat (8) @(posedge clk);
    chk("request pins", {30'h0, irq, fiq}, {30'h0, e});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    error_cnt = 0;
    n_checks = 0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    // Low-level externals and the fast line start inactive so nothing pends by default.
    lvl = 32'h0007_0001;
    rst = 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdc(vpic_pkg::OFS_MASK, 32'h0000_0000);
    rdc(md(2), vpic_pkg::MODE_RESET);
    wr(md(9), 32'hFFFF_FFFF);
    rdc(md(9), 32'h0000_0000);
    wr(vpic_pkg::OFS_VECTOR_BASE + 12'h050, 32'hFFFF_FFFF);
    rdc(vpic_pkg::OFS_VECTOR_BASE + 12'h050, 32'h0000_0000);
    rd(12'h118);
    chk("response", {30'h0, rsp}, {30'h0, vpic_pkg::RESP_SLVERR});
    for (int k = 0; k < 19; k++) wr(vpic_pkg::OFS_VECTOR_BASE + 12'(4 * k), vec(k));
    wr(md(1), 32'h0000_0022);
    wr(md(3), 32'h0000_0025);
    wr(md(4), 32'h0000_0025);
    wr(md(16), 32'h0000_0066);
    wr(vpic_pkg::OFS_SPURIOUS, 32'h0000_0EEE);
    wstrb <= 4'h3;
    wr(vpic_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    rdc(vpic_pkg::OFS_MASK, 32'h0000_0000);
    wr(vpic_pkg::OFS_ENABLE, 32'h0001_001A);
    rdc(vpic_pkg::OFS_MASK, 32'h0001_001A);
    wr(vpic_pkg::OFS_SET, 32'h0000_001A);
    pins(2'h2);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(3));
    rdc(vpic_pkg::OFS_STATUS, 32'h0000_0003);
    pins(2'h0);
    rdc(vpic_pkg::OFS_PENDING, 32'h0000_0012);
    wr(vpic_pkg::OFS_SET, 32'h0001_0000);
    pins(2'h2);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(16));
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    pins(2'h0);
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    pins(2'h2);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(4));
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    pins(2'h2);
    wr(vpic_pkg::OFS_SET, 32'h0000_0008);
    pins(2'h2);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(3));
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    pins(2'h2);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(1));
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, 32'h0000_0EEE);
    wr(vpic_pkg::OFS_SET, 32'h0000_0002);
    pins(2'h0);
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    pins(2'h2);
    wr(vpic_pkg::OFS_DISABLE, 32'h0000_0008);
    wr(vpic_pkg::OFS_SET, 32'h0000_0008);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(1));
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    wr(vpic_pkg::OFS_CLEAR, 32'h0000_0008);
    rdc(vpic_pkg::OFS_PENDING, 32'h0000_0000);
    wr(vpic_pkg::OFS_ENABLE, 32'h0000_0008);
    wr(vpic_pkg::OFS_SET, 32'h0000_0008);
    pins(2'h2);
    wr(vpic_pkg::OFS_IRQ_VECTOR, 32'h0000_0000);
    pins(2'h2);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(3));
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    wr(vpic_pkg::OFS_PROTECT, 32'h0000_0001);
    wr(vpic_pkg::OFS_SET, 32'h0000_0002);
    pins(2'h2);
    rdc(vpic_pkg::OFS_IRQ_VECTOR, vec(1));
    rdc(vpic_pkg::OFS_STATUS, 32'h0000_0000);
    wr(vpic_pkg::OFS_IRQ_VECTOR, 32'h0000_0000);
    rdc(vpic_pkg::OFS_STATUS, 32'h0000_0001);
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    wr(vpic_pkg::OFS_PROTECT, 32'h0000_0000);
    // Each fast mode is armed while masked, then any edge latched by the switch is cleared.
    for (int t = 0; t < 4; t++) begin
      wr(vpic_pkg::OFS_DISABLE, 32'h0000_0001);
      lvl[0] <= ~t[1];
      wr(md(0), {25'h0, 2'(t), 5'h07});
      pins(2'h0);
      wr(vpic_pkg::OFS_CLEAR, 32'h0000_0001);
      wr(vpic_pkg::OFS_ENABLE, 32'h0000_0001);
      pins(2'h0);
      lvl[0] <= t[1];
      pins(2'h1);
      rdc(vpic_pkg::OFS_FAST_VECTOR, vec(0));
      lvl[0] <= ~t[1];
      pins(2'h0);
    end
    end_of_test();
  end
endmodule // tb_top

/* File: dv/vpic_controller_chk.sv */
// Checker for bus answers and request pins of the interrupt controller.
`timescale 1ns/1ps
module vpic_controller_chk #(
  parameter int unsigned NUM_SOURCES = vpic_pkg::NUM_SOURCES,
  parameter int unsigned STACK_DEPTH = vpic_pkg::STACK_DEPTH
) (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [31:0] sources_i,
  input wire logic        core_irq_request_o,
  input wire logic        core_fast_irq_request_o,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  logic [31:0] mask_m;
  logic [11:0] rd_addr;
  logic        prot_m, wr_take, wr_go, rd_go;
  assign wr_take = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign wr_go = wr_take && (s_axi_wstrb_i == 4'hF);
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  // Mask and protect bit are rebuilt from the bus, so partial-strobe writes are left out.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask_m <= 32'h0000_0000;
      prot_m <= 1'h0;
    end else if (wr_go) begin
      if (s_axi_awaddr_i == vpic_pkg::OFS_ENABLE) mask_m <= mask_m | (s_axi_wdata_i & vpic_pkg::SOURCES_PRESENT);
      if (s_axi_awaddr_i == vpic_pkg::OFS_DISABLE) mask_m <= mask_m & ~s_axi_wdata_i;
      if (s_axi_awaddr_i == vpic_pkg::OFS_PROTECT) prot_m <= s_axi_wdata_i[0];
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) rd_addr <= 12'h000;
    else if (rd_go) rd_addr <= s_axi_araddr_i;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (rd_go |=> s_axi_rvalid_o)
    else $error("read answer missing");
  a_write_answer: assert property (wr_take |=> s_axi_bvalid_o)
    else $error("write answer missing");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  a_mask_readback: assert property (s_axi_rvalid_o && rd_addr == vpic_pkg::OFS_MASK |-> s_axi_rdata_o == mask_m)
    else $error("mask readback wrong");
  a_reserved_zero: assert property (rd_go && s_axi_araddr_i < vpic_pkg::OFS_IRQ_VECTOR &&
    !vpic_pkg::SOURCES_PRESENT[s_axi_araddr_i[6:2]] |=> s_axi_rdata_o == 32'h0000_0000) else $error("reserved not zero");
  a_unmapped_err: assert property (rd_go && (s_axi_araddr_i == 12'h118 || s_axi_araddr_i > vpic_pkg::OFS_PROTECT)
    |=> s_axi_rresp_o == vpic_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  a_vector_drop: assert property (rd_go && s_axi_araddr_i == vpic_pkg::OFS_IRQ_VECTOR && !prot_m
    |-> ##[1:2] !core_irq_request_o) else $error("request kept after vector read");
  a_normal_write: assert property (wr_go && s_axi_awaddr_i == vpic_pkg::OFS_IRQ_VECTOR && !prot_m &&
    core_irq_request_o |=> core_irq_request_o [*2]) else $error("vector write had effect");
  a_fast_masked: assert property ((!mask_m[0]) [*6] |-> !core_fast_irq_request_o)
    else $error("fast request while disabled");
  a_irq_masked: assert property ((mask_m == 32'h0000_0000) [*6] |-> !core_irq_request_o)
    else $error("request with all disabled");
  c_vector_read: cover property (rd_go && s_axi_araddr_i == vpic_pkg::OFS_IRQ_VECTOR);
  c_irq_rise: cover property ($rose(core_irq_request_o));
  c_fast_rise: cover property ($rose(core_fast_irq_request_o));
endmodule // vpic_controller_chk
bind vpic_controller vpic_controller_chk #(.NUM_SOURCES(NUM_SOURCES), .STACK_DEPTH(STACK_DEPTH)) vpic_chk_inst (.*);

/* File: dv/vpic_src_model.sv */
// Model of the peripheral and external lines that feed the controller.
`timescale 1ns/1ps
module vpic_src_model (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] level_i,
  output logic [31:0]      sources_o
);
  // Lines move just after an edge, as a peripheral flop would drive them.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) sources_o <= 32'h0000_0000;
    else sources_o <= level_i;
  end
endmodule // vpic_src_model
